// *** hbw_consts.vh ***
`ifndef HBW_CONSTS_VH
`define HBW_CONSTS_VH
`define HBW_ADDR_W 15
`define HBW_WORD_W 15
`define HBW_CODE_W 22
`define HBW_SPACE_FULL 15'h7fff
`define HBW_SPACE_EDC 15'h5fff
`define HBW_BYTE_LO 1'b0
`endif

// *** hbw_host_bfm.sv ***
`timescale 1ns/100ps
module hbw_host_bfm (
    input wire clk_i,
    output reg cs_n_o = 1'b1,
    output reg wr_n_o = 1'b1,
    output reg rd_n_o = 1'b1,
    output reg [14:0] addr_o = 15'h0,
    output reg [15:0] data_o = 16'h0
);
    task cyc(input wr, input sel, input [14:0] a, input [15:0] d);
    begin
        @(posedge clk_i);
        #1;
        addr_o = a;
        data_o = d;
        cs_n_o = !sel;
        @(posedge clk_i);
        #1;
        wr_n_o = !wr;
        rd_n_o = wr;
        repeat (8) @(posedge clk_i);
        #1;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        data_o = ~d;
        repeat (4) @(posedge clk_i);
        #1;
        cs_n_o = 1'b1;
    end
    endtask
endmodule

// *** hbw_host_port.v ***
`timescale 1ns/100ps
`include "hbw_consts.vh"
module hbw_host_port (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire cs_n_i,
    input wire wr_n_i,
    input wire rd_n_i,
    input wire [14:0] addr_i,
    input wire [15:0] data_i,
    output reg [15:0] data_o,
    output reg [15:0] data_oe_o,
    input wire bus_width_strap_i,
    input wire byte_order_strap_i,
    input wire ram_correction_strap_i,
    input wire test_strap_i,
    input wire ser_word_valid_i,
    input wire [15:0] ser_word_i,
    output reg [7:0] ser_byte_o,
    output reg ser_byte_valid_o,
    input wire corr_evt_en_i,
    input wire fail_evt_en_i,
    output reg corr_evt_o,
    output reg fail_evt_o,
    output reg test_mode_o,
    output reg edc_on_o,
    output reg wide_o,
    output reg range_err_o
);
    reg cs_m;
    reg cs_s;
    reg wr_m;
    reg wr_s;
    reg rd_m;
    reg rd_s;
    reg [14:0] a_m, a_s;
    reg [15:0] d_m, d_s;
    reg bw_m;
    reg bw_s;
    reg bo_m;
    reg bo_s;
    reg ec_m;
    reg ec_s;
    reg ts_m;
    reg ts_s;
    reg wr_q;
    reg rd_q;
    reg [7:0] hold_byte;
    reg [15:0] rd_word;
    reg [7:0] ser_hold;
    reg ser_pend;
    reg rd_pend;
    reg rd_wait;
    reg [`HBW_WORD_W-1:0] ram_a;
    reg ram_we;
    reg [`HBW_CODE_W-1:0] ram_wd;
    wire [`HBW_CODE_W-1:0] ram_rd;
    wire wr_go;
    wire rd_go;
    wire [`HBW_WORD_W-1:0] waddr;
    wire in_range;
    wire first_byte;
    wire hi_first;
    wire [4:0] syn_bit;
    genvar g;
    reg [5:0] syn;
    reg [15:0] fixed;
    reg dbl;

    // Hamming SECDED: 16 data bits, 5 check bits, 1 overall parity
    function [`HBW_CODE_W-1:0] enc;
        input [15:0] d;
        reg [20:0] c;
        integer i;
        integer k;
        begin
            c = 21'h0;
            k = 0;
            for (i = 1; i <= 21; i = i + 1)
                if ((i & (i - 1)) != 0)
                begin
                    c[i-1] = d[k];
                    k = k + 1;
                end
            for (i = 0; i < 5; i = i + 1)
                c[(1<<i)-1] = ^(c & pmask(i));
            enc = {^c, c};
        end
    endfunction

    function [20:0] pmask;
        input integer b;
        integer j;
        begin
            pmask = 21'h0;
            for (j = 1; j <= 21; j = j + 1)
                pmask[j-1] = ((j >> b) & 1) != 0;
        end
    endfunction

    function [15:0] extract;
        input [20:0] c;
        integer i;
        integer k;
        begin
            extract = 16'h0000;
            k = 0;
            for (i = 1; i <= 21; i = i + 1)
                if ((i & (i - 1)) != 0)
                begin
                    extract[k] = c[i-1];
                    k = k + 1;
                end
        end
    endfunction

    // Pins come from outside the clock domain
    always @(posedge sys_clk_i)
    begin
        cs_m <= cs_n_i;
        cs_s <= cs_m;
        wr_m <= wr_n_i;
        wr_s <= wr_m;
        rd_m <= rd_n_i;
        rd_s <= rd_m;
        a_m <= addr_i;
        a_s <= a_m;
        d_m <= data_i;
        d_s <= d_m;
        bw_m <= bus_width_strap_i;
        bw_s <= bw_m;
        bo_m <= byte_order_strap_i;
        bo_s <= bo_m;
        ec_m <= ram_correction_strap_i;
        ec_s <= ec_m;
        ts_m <= test_strap_i;
        ts_s <= ts_m;
    end

    // Strobe edges only count while selected
    assign wr_go = !cs_s && !wr_s && wr_q;
    assign rd_go = !cs_s && !rd_s && rd_q;
    // Word address skips A0 either way
    assign waddr = {1'b0, a_s[14:1]};
    // Fourteen address lines never pass the 24K limit; kept for wider hosts
    assign in_range = !ec_s
        || (waddr <= `HBW_SPACE_EDC);
    // Byte-order strap only matters to host transfers in 8-bit mode; the serial path always follows it
    assign hi_first = !bw_s && bo_s;
    // Host marks the first byte of a word with A0 low
    assign first_byte = (a_s[0] == `HBW_BYTE_LO);

    // One parity group per check bit
    generate
        for (g = 0; g < 5; g = g + 1)
        begin : g_syn
            assign syn_bit[g] = ^(ram_rd[20:0] & pmask(g));
        end
    endgenerate

    always @*
    begin
        syn[4:0] = syn_bit;
        syn[5] = ^ram_rd;
        fixed = extract(ram_rd[20:0]);
        dbl = 1'b0;
        if (ec_s)
        begin
            if (syn[5] && syn[4:0] != 5'h00 && syn[4:0] <= 5'h15)
                fixed = extract(ram_rd[20:0]
                    ^ (21'h1 << (syn[4:0] - 5'h01)));
            else if (!syn[5] && syn[4:0] != 5'h00)
                dbl = 1'b1;
        end
    end

    hbw_ram #(
        .WIDTH(`HBW_CODE_W),
        .AW(`HBW_WORD_W)
    ) u_ram (
        .sys_clk_i(sys_clk_i),
        .we_i(ram_we),
        .addr_i(ram_a),
        .wdata_i(ram_wd),
        .rdata_o(ram_rd)
    );

    always @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            wr_q <= 1'b1;
            rd_q <= 1'b1;
            hold_byte <= 8'h00;
            rd_word <= 16'h0000;
            rd_pend <= 1'b0;
            rd_wait <= 1'b0;
            ram_a <= 15'h0;
            ram_we <= 1'b0;
            ram_wd <= 22'h0;
            data_o <= 16'h0000;
            data_oe_o <= 16'h0000;
            corr_evt_o <= 1'b0;
            fail_evt_o <= 1'b0;
            test_mode_o <= 1'b0;
            edc_on_o <= 1'b0;
            wide_o <= 1'b0;
            range_err_o <= 1'b0;
        end
        else
        begin
            wr_q <= wr_s;
            rd_q <= rd_s;
            ram_we <= 1'b0;
            rd_pend <= 1'b0;
            rd_wait <= rd_pend;
            corr_evt_o <= 1'b0;
            fail_evt_o <= 1'b0;
            range_err_o <= 1'b0;
            wide_o <= bw_s;
            edc_on_o <= ec_s;
            test_mode_o <= ts_s;
            // Drive only while a read is in progress
            if (!cs_s && !rd_s)
                data_oe_o <= bw_s ? 16'hffff : 16'h00ff;
            else
                data_oe_o <= 16'h0000;
            if (wr_go)
            begin
                if (!in_range)
                    range_err_o <= 1'b1;
                else if (bw_s)
                begin
                    ram_a <= waddr;
                    ram_wd <= enc(d_s);
                    ram_we <= 1'b1;
                end
                else if (first_byte)
                    hold_byte <= d_s[7:0];
                else
                begin
                    ram_a <= waddr;
                    // First byte goes to the high half only when the strap selects high first
                    ram_wd <= hi_first ? enc({hold_byte, d_s[7:0]})
                        : enc({d_s[7:0], hold_byte});
                    ram_we <= 1'b1;
                end
            end
            // Fetch on first byte; second byte reuses the latched word
            if (rd_go && (bw_s || first_byte))
            begin
                if (!in_range)
                    range_err_o <= 1'b1;
                else
                begin
                    ram_a <= waddr;
                    rd_pend <= 1'b1;
                end
            end
            else if (rd_go)
                data_o <= {8'h00, hi_first ? rd_word[7:0] : rd_word[15:8]};
            // RAM output register adds a cycle after the address
            if (rd_wait)
            begin
                rd_word <= fixed;
                corr_evt_o <= corr_evt_en_i && ec_s && syn[5];
                fail_evt_o <= fail_evt_en_i && dbl;
                if (bw_s)
                    data_o <= fixed;
                else
                    data_o <= {8'h00, hi_first ? fixed[15:8] : fixed[7:0]};
            end
        end
    end

    // A new word during the second byte drops that byte
    always @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            ser_byte_o <= 8'h00;
            ser_byte_valid_o <= 1'b0;
            ser_hold <= 8'h00;
            ser_pend <= 1'b0;
        end
        else
        begin
            ser_byte_valid_o <= 1'b0;
            if (ser_word_valid_i)
            begin
                ser_byte_o <= bo_s ? ser_word_i[15:8]
                    : ser_word_i[7:0];
                ser_hold <= bo_s ? ser_word_i[7:0] : ser_word_i[15:8];
                ser_byte_valid_o <= 1'b1;
                ser_pend <= 1'b1;
            end
            else if (ser_pend)
            begin
                ser_byte_o <= ser_hold;
                ser_byte_valid_o <= 1'b1;
                ser_pend <= 1'b0;
            end
        end
    end
endmodule

// *** hbw_host_port_props.sv ***
`timescale 1ns/100ps
module hbw_host_port_props (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire rd_n_i,
    input wire bus_width_strap_i,
    input wire ram_correction_strap_i,
    input wire test_strap_i,
    input wire corr_evt_en_i,
    input wire fail_evt_en_i,
    input wire ser_word_valid_i,
    input wire [15:0] data_oe_o,
    input wire ser_byte_valid_o,
    input wire corr_evt_o,
    input wire fail_evt_o,
    input wire test_mode_o,
    input wire edc_on_o,
    input wire wide_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Six edges cover the two-stage sync plus the output register
    sequence s_held(s);
        $stable(s) [*6];
    endsequence
    sequence s_no_read;
        rd_n_i [*6];
    endsequence
    chk_oe_idle: assert property
        (s_no_read |-> data_oe_o == 16'h0)
        else $error("data lines driven outside a read");
    chk_narrow_upper: assert property
        (!wide_o |-> data_oe_o[15:8] == 8'h0)
        else $error("upper lines driven in byte mode");
    chk_wide_strap: assert property
        (s_held(bus_width_strap_i) |-> wide_o == bus_width_strap_i)
        else $error("width does not follow strap");
    chk_edc_strap: assert property
        (s_held(ram_correction_strap_i) |-> edc_on_o == ram_correction_strap_i)
        else $error("correction mode does not follow strap");
    chk_test_strap: assert property
        (s_held(test_strap_i) |-> test_mode_o == test_strap_i)
        else $error("test mode does not follow strap");
    chk_corr_gate: assert property
        (!corr_evt_en_i [*3] |-> !corr_evt_o)
        else $error("corrected event while disabled");
    chk_fail_gate: assert property
        (!fail_evt_en_i [*3] |-> !fail_evt_o)
        else $error("uncorrectable event while disabled");
    chk_evt_edc: assert property
        ((corr_evt_o || fail_evt_o) |-> edc_on_o)
        else $error("error event with correction off");
    chk_ser_pair: assert property
        ($rose(ser_byte_valid_o) |=> ser_byte_valid_o ##1 !ser_byte_valid_o)
        else $error("serial word not two bytes");
    chk_ser_answer: assert property
        (ser_word_valid_i |-> ##[1:6] $rose(ser_byte_valid_o))
        else $error("serial word not sent");
endmodule
bind hbw_host_port hbw_host_port_props chk_u (.*);

// *** hbw_host_port_tb.sv ***
`timescale 1ns/100ps
module hbw_host_port_tb;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg bw = 1'b1, bo = 1'b0, ec = 1'b0, ts = 1'b0, cen = 1'b0, swv = 1'b0;
    reg [15:0] sw = 16'h0;
    reg [15:0] d, q;
    reg [13:0] wa;
    integer m, n, miscompares = 0, total_checks = 0;
    integer e0, e1, ce_n = 0, fe_n = 0, re_n = 0;
    wire cs_n, wr_n, rd_n, sbv, tm, eo, wo, ce, fe, re;
    wire [14:0] a;
    wire [15:0] hd, rd, oe, bus;
    wire [7:0] sb;
    assign bus = (oe & rd) | (~oe & hd);
    hbw_host_bfm host_u (.clk_i(clk), .cs_n_o(cs_n), .wr_n_o(wr_n),
        .rd_n_o(rd_n), .addr_o(a), .data_o(hd));
    hbw_host_port dut_u (.sys_clk_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n),
        .wr_n_i(wr_n), .rd_n_i(rd_n), .addr_i(a), .data_i(bus),
        .data_o(rd), .data_oe_o(oe), .bus_width_strap_i(bw),
        .byte_order_strap_i(bo), .ram_correction_strap_i(ec),
        .test_strap_i(ts), .ser_word_valid_i(swv), .ser_word_i(sw),
        .ser_byte_o(sb), .ser_byte_valid_o(sbv), .corr_evt_en_i(cen),
        .fail_evt_en_i(cen), .corr_evt_o(ce), .fail_evt_o(fe),
        .test_mode_o(tm), .edc_on_o(eo), .wide_o(wo), .range_err_o(re));
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // Event pulses last one cycle; count them for later comparison
    always @(posedge clk)
    begin
        if (ce === 1'b1)
            ce_n <= ce_n + 1;
        if (fe === 1'b1)
            fe_n <= fe_n + 1;
        if (re === 1'b1)
            re_n <= re_n + 1;
    end
    task conclude;
    begin
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    task chk(input [15:0] g, input [15:0] e);
    begin
        total_checks = total_checks + 1;
        if (g !== e)
        begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    end
    endtask
    task chk_b(input [7:0] g, input [7:0] e);
        chk({8'h0, g}, {8'h0, e});
    endtask
    task straps(input w, input o, input e);
    begin
        bw = w;
        bo = o;
        ec = e;
        ts = $urandom;
        cen = $urandom;
        repeat (6) @(posedge clk);
        #1;
    end
    endtask
    // Upper lines carry junk in byte mode; they must be ignored
    task xfer(input wr, input [15:0] v);
        reg [7:0] b;
    begin
        if (bw)
        begin
            host_u.cyc(wr, 1'b1, {wa, d[0]}, v);
            q = rd;
        end
        else
        begin
            host_u.cyc(wr, 1'b1, {wa, 1'b0},
                {8'ha5, bo ? v[15:8] : v[7:0]});
            b = rd[7:0];
            host_u.cyc(wr, 1'b1, {wa, 1'b1},
                {8'h5a, bo ? v[7:0] : v[15:8]});
            q = bo ? {b, rd[7:0]} : {rd[7:0], b};
        end
    end
    endtask
    initial
    begin
        m = $urandom(32'he4f6e51a);
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        for (m = 0; m < 8; m = m + 1)
        begin
            wa = $urandom;
            d = $urandom;
            straps(1'b1, $urandom, m[2]);
            xfer(1'b1, d);
            straps(m[0], m[1], m[2]);
            chk({13'h0, tm, eo, wo},
                {13'h0, ts, ec, bw});
            xfer(1'b0, 16'h0);
            chk(q, d);
            d = ~d;
            xfer(1'b1, d);
            host_u.cyc(1'b1, 1'b0, {wa, 1'b0}, ~d);
            straps(1'b1, ~m[1], m[2]);
            xfer(1'b0, 16'h0);
            chk(q, d);
            $display("test %0d done", m);
        end
        // Flip stored code bits behind the port to exercise correction
        for (m = 0; m < 4; m = m + 1)
        begin
            wa = $urandom;
            d = $urandom;
            straps(1'b1, 1'b0, 1'b1);
            cen = m[0];
            xfer(1'b1, d);
            n = $urandom % 21;
            dut_u.u_ram.mem[wa][n] = ~dut_u.u_ram.mem[wa][n];
            if (m[1])
                dut_u.u_ram.mem[wa][n + 1] = ~dut_u.u_ram.mem[wa][n + 1];
            e0 = ce_n;
            e1 = fe_n;
            xfer(1'b0, 16'h0);
            if (!m[1])
                chk(q, d);
            chk(ce_n - e0, {15'h0, m[0] & !m[1]});
            chk(fe_n - e1, {15'h0, m[0] & m[1]});
            $display("edc %0d done", m);
        end
        for (m = 0; m < 2; m = m + 1)
        begin
            straps(1'b1, m[0], 1'b0);
            sw = $urandom;
            swv = 1'b1;
            @(posedge clk);
            #1;
            swv = 1'b0;
            for (n = 0; n < 9 && sbv !== 1'b1; n = n + 1)
                @(posedge clk) #1;
            chk({15'h0, sbv}, 16'h1);
            chk_b(sb, m[0] ? sw[15:8] : sw[7:0]);
            @(posedge clk);
            #1;
            chk_b(sb, m[0] ? sw[7:0] : sw[15:8]);
            $display("serial %0d done", m);
        end
        chk(re_n, 16'h0);
        conclude;
    end
    initial
    begin
        #100000;
        miscompares = miscompares + 1;
        conclude;
    end
endmodule

// *** hbw_ram.v ***
`timescale 1ns/100ps
module hbw_ram #(
    parameter WIDTH = 22,
    parameter AW = 15
)
(
    input wire sys_clk_i,
    input wire we_i,
    input wire [AW-1:0] addr_i,
    input wire [WIDTH-1:0] wdata_i,
    output reg [WIDTH-1:0] rdata_o
);
    reg [WIDTH-1:0] mem [0:(1<<AW)-1];
    always @(posedge sys_clk_i)
    begin
        if (we_i)
            mem[addr_i] <= wdata_i;
        rdata_o <= mem[addr_i];
    end
endmodule
